// ---- rtl/arbcr_regs.sv ----
// Register bank for the converter front end: repeat control, buffer configuration,
// calibration lock and per-channel offset/gain calibration, plus the correction datapath.
// Assumes an AXI4-Lite master on the same clock and converter samples on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [RULE1] Repeat count sits in bits 11:4; 1 means one, 0xFF 255 conversions; never zero. A written zero is stored as is.
// [RULE2] Bit 0 of repeat control enables repeated conversions when set.
// [RULE3] Repeat control resets to 0x160: count 0x16, repeating off.
// [RULE4] Amplifier-off bits 8:4 power an amplifier down when 1, up when 0.
// [RULE5] Bits 8..4: offset-cancel buffers, converter buffers, PGA, positive, negative buffer.
// [RULE6] Chopping-off bits 3:0 stop chopping for a stage when 1.
// [RULE7] Bits 3..0: offset-cancel buffers, converter buffers, PGA, both front-end buffers.
// [RULE8] Software clears chopping-off bits below 80 kHz, sets them above.
// [RULE9] Software programs buffer word 0x005F3D0F high power, 0x005F3D04 low power.
// [RULE10] Buffer configuration resets to 0x005F3D00, amplifier field 0x10, chopping on.
// [RULE11] Writing key 0xDE87A5AF to the lock register unlocks calibration writes.
// [RULE12] Without the key, calibration writes are ignored; key is 32 bits, resets zero.
// [RULE13] Every gain calibration register resets to unity, 0x4000.
// [RULE14] Every offset calibration register resets to zero.
// [RULE15] Separate offset/gain pairs for low power, high speed, temperature, aux gains.
// [RULE16] Offset is 15-bit two's complement in quarter result LSBs.
// [RULE17] Gain 0x4000 is unity, 0x7FFF doubles; zero forces a zero result.
// [RULE18] Each sample is corrected with the pair of its selected channel and gain.
// [RULE19] Reserved bits read zero and ignore writes.
module arbcr_regs (
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [arbcr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [arbcr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Converter side
  input wire arbcr_pkg::arbcr_sample_t sample,
  output arbcr_pkg::arbcr_result_t result,
  output arbcr_pkg::arbcr_analog_t analogCtrl,
  output logic calUnlocked
);
  import arbcr_pkg::*;

  // ===========================================================================
  // Storage
  logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
  arbcr_addr_t wAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] repeat_ff, bufcfg_ff, lockKey_ff;
  logic [CAL_W-1:0] calOfs_ff [NUM_CAL];
  logic [CAL_W-1:0] calGain_ff [NUM_CAL];
  arbcr_result_t result_ff;
  logic writeFire;
  logic [NUM_CAL-1:0] ofsHit, gainHit;
  logic wrRepeat, wrBufcfg, wrLock, wrMapped;
  logic [31:0] rdMux;
  logic rdHit;

  // Merge a write into an old word under byte strobes
  function automatic logic [31:0] strobed(input logic [31:0] oldVal,
                                          input logic [31:0] newVal,
                                          input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction : strobed

  // ===========================================================================
  // Write channel: address and data are caught independently, in either order
  assign awready = !awHeld_ff && !bvalid_ff;
  assign wready = !wHeld_ff && !bvalid_ff;
  assign writeFire = awHeld_ff && wHeld_ff && !bvalid_ff;

  // Address holding flag; a new address waits until the response is accepted
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awHeld_ff <= 1'b0;
    end
    else if (awvalid && awready)
    begin
      awHeld_ff <= 1'b1;
    end
    else if (writeFire)
    begin
      awHeld_ff <= 1'b0;
    end
  end

  // Captured write address
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wAddr_ff <= '0;
    end
    else if (awvalid && awready)
    begin
      wAddr_ff <= awaddr;
    end
  end

  // Data holding flag and captured data with strobes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wHeld_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end
    else if (wvalid && wready)
    begin
      wHeld_ff <= 1'b1;
      wData_ff <= wdata;
      wStrb_ff <= wstrb;
    end
    else if (writeFire)
    begin
      wHeld_ff <= 1'b0;
    end
  end

  // Decode of the held write address
  assign wrRepeat = writeFire && (wAddr_ff == ADDR_REPEAT);
  assign wrBufcfg = writeFire && (wAddr_ff == ADDR_BUFCFG);
  assign wrLock = writeFire && (wAddr_ff == ADDR_LOCK);
  assign wrMapped = wrRepeat || wrBufcfg || wrLock || (|ofsHit) || (|gainHit);

  // Response; a locked calibration write still answers OKAY, it is only ignored
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (writeFire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_ff && bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ===========================================================================
  // Control registers
  // Repeat control: only count and enable are stored, the rest reads zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      repeat_ff <= REPEAT_RST; // RULE3
    end
    else if (wrRepeat)
    begin
      repeat_ff <= strobed(repeat_ff, wData_ff, wStrb_ff) & REPEAT_MASK; // RULE1 RULE2 RULE19
    end
  end

  // Buffer configuration: low nine bits writable, upper image fixed
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bufcfg_ff <= BUFCFG_RST; // RULE10
    end
    else if (wrBufcfg)
    begin
      bufcfg_ff <= (strobed(bufcfg_ff, wData_ff, wStrb_ff) & BUFCFG_MASK) | BUFCFG_FIXED;
    end
  end

  // Lock key: any value may be written, only the exact key opens the bank
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lockKey_ff <= LOCK_RST; // RULE12
    end
    else if (wrLock)
    begin
      lockKey_ff <= strobed(lockKey_ff, wData_ff, wStrb_ff);
    end
  end

  assign calUnlocked = (lockKey_ff == CAL_KEY); // RULE11

  // Analog controls come straight from the stored fields; a one amplifier or chopping bit means off
  // One assignment for the whole struct, so the output has a single driver
  assign analogCtrl = '{repeatEnable: repeat_ff[REP_EN_BIT], // RULE2
                        repeatCount: repeat_ff[REP_CNT_MSB:REP_CNT_LSB], // RULE1
                        amplifierOffBits: bufcfg_ff[AMP_MSB:AMP_LSB], // RULE4 RULE5
                        choppingOffBits: bufcfg_ff[CHOP_MSB:0]}; // RULE6 RULE7

  // ===========================================================================
  // Calibration pairs, one per channel and gain setting
  for (genvar g = 0; g < NUM_CAL; g++)
  begin : g_cal
    logic [31:0] ofsMerged, gainMerged;
    assign ofsHit[g] = writeFire && (wAddr_ff == OFS_ADDR[g]);
    assign gainHit[g] = writeFire && (wAddr_ff == GAIN_ADDR[g]);
    assign ofsMerged = strobed({17'h0, calOfs_ff[g]}, wData_ff, wStrb_ff);
    assign gainMerged = strobed({17'h0, calGain_ff[g]}, wData_ff, wStrb_ff);

    // Offset value; writes only land while the key is present
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        calOfs_ff[g] <= OFS_ZERO; // RULE14
      end
      else if (ofsHit[g] && calUnlocked)
      begin
        calOfs_ff[g] <= ofsMerged[CAL_W-1:0]; // RULE12 RULE15 RULE16
      end
    end

    // Gain value; protected the same way
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        calGain_ff[g] <= GAIN_UNITY; // RULE13
      end
      else if (gainHit[g] && calUnlocked)
      begin
        calGain_ff[g] <= gainMerged[CAL_W-1:0]; // RULE12 RULE15 RULE17
      end
    end
  end

  // ===========================================================================
  // Read channel: one read in flight, data registered
  assign arready = !rvalid_ff;

  // Read decode; unmapped addresses read zero with an error response
  always_comb
  begin
    rdMux = '0;
    rdHit = 1'b0;
    if (araddr == ADDR_REPEAT)
    begin
      rdMux = repeat_ff;
      rdHit = 1'b1;
    end
    else if (araddr == ADDR_BUFCFG)
    begin
      rdMux = bufcfg_ff;
      rdHit = 1'b1;
    end
    else if (araddr == ADDR_LOCK)
    begin
      rdMux = lockKey_ff;
      rdHit = 1'b1;
    end
    for (int i = 0; i < NUM_CAL; i++)
    begin
      if (araddr == OFS_ADDR[i])
      begin
        rdMux = {17'h0, calOfs_ff[i]}; // RULE19
        rdHit = 1'b1;
      end
      if (araddr == GAIN_ADDR[i])
      begin
        rdMux = {17'h0, calGain_ff[i]}; // RULE19
        rdHit = 1'b1;
      end
    end
  end

  // Read response holds until the master takes it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rdMux;
      rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_ff && rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ===========================================================================
  // Correction datapath: ((raw*4 + offset) * gain) >> 16, clamped to 16 bits
  logic [CAL_W-1:0] selOfs, selGain;
  logic signed [19:0] sumQ;
  logic signed [35:0] prodQ;
  logic signed [19:0] scaledQ;
  logic [15:0] clampQ;

  assign selOfs = calOfs_ff[sample.chan]; // RULE18
  assign selGain = calGain_ff[sample.chan]; // RULE18

  // Offset in quarter LSBs, so the raw code is lifted by two bits first;
  // a spare top bit keeps full scale plus the largest offset from wrapping negative
  always_comb
  begin
    sumQ = $signed({2'b00, sample.raw, 2'b00}) + $signed({{5{selOfs[CAL_W-1]}}, selOfs}); // RULE16
    prodQ = sumQ * $signed({1'b0, selGain}); // RULE17
    scaledQ = prodQ[35:CAL_SHIFT];
    if (scaledQ < 0)
    begin
      clampQ = '0;
    end
    else if (scaledQ > $signed({4'b0000, RESULT_MAX}))
    begin
      clampQ = RESULT_MAX;
    end
    else
    begin
      clampQ = scaledQ[15:0];
    end
  end

  // One cycle of latency; zero gain forces zero even if the clamp would not
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      result_ff <= '0;
    end
    else
    begin
      result_ff.valid <= sample.valid;
      if (sample.valid)
      begin
        result_ff.data <= (selGain == GAIN_ZERO) ? 16'h0000 : clampQ; // RULE17 RULE18
      end
    end
  end

  assign result = result_ff;

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_reg_write(arbcr_addr_t a);
    writeFire && (wAddr_ff == a);
  endsequence

  sequence s_both_held;
    awHeld_ff && wHeld_ff && !bvalid_ff;
  endsequence

  property p_reset_values;
    $past(rst) |-> (repeat_ff == REPEAT_RST) && (bufcfg_ff == BUFCFG_RST)
      && (lockKey_ff == LOCK_RST) && (calGain_ff[0] == GAIN_UNITY)
      && (calOfs_ff[NUM_CAL-1] == OFS_ZERO);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Bad reset value"); // RULE3

  property p_repeat_write;
    s_reg_write(ADDR_REPEAT) ##0 (wStrb_ff == 4'hF) |=>
      (analogCtrl.repeatEnable == $past(wData_ff[REP_EN_BIT]))
      && (analogCtrl.repeatCount == $past(wData_ff[REP_CNT_MSB:REP_CNT_LSB]));
  endproperty
  a_repeat_write: assert property (p_repeat_write) else $error("Repeat field lost"); // RULE2

  property p_bufcfg_write;
    s_reg_write(ADDR_BUFCFG) ##0 (wStrb_ff == 4'hF) |=>
      (analogCtrl.amplifierOffBits == $past(wData_ff[AMP_MSB:AMP_LSB]))
      && (analogCtrl.choppingOffBits == $past(wData_ff[CHOP_MSB:0]));
  endproperty
  a_bufcfg_write: assert property (p_bufcfg_write) else $error("Buffer field lost"); // RULE4

  property p_locked_hold;
    s_reg_write(GAIN_ADDR[2]) ##0 !calUnlocked |=> $stable(calGain_ff[2]);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("Locked write landed"); // RULE12

  property p_unlocked_write;
    s_reg_write(OFS_ADDR[1]) ##0 (calUnlocked && (wStrb_ff == 4'hF)) |=>
      (calOfs_ff[1] == $past(wData_ff[CAL_W-1:0]));
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("Unlocked write lost"); // RULE11

  property p_write_response;
    s_both_held |=> bvalid_ff ##0 (!awHeld_ff && !wHeld_ff);
  endproperty
  a_write_response: assert property (p_write_response) else $error("No write answer"); // RULE19

  property p_reserved_read;
    (arvalid && arready && (araddr == GAIN_ADDR[2])) |=>
      rvalid_ff && (rdata_ff[31:CAL_W] == 17'h0);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("Reserved bits set"); // RULE19

  property p_read_hold;
    rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("Read data dropped"); // RULE19

  property p_gain_zero;
    sample.valid && (selGain == GAIN_ZERO) |=> result.valid && (result.data == 16'h0000);
  endproperty
  a_gain_zero: assert property (p_gain_zero) else $error("Zero gain not zero"); // RULE17

  property p_unity_pass;
    sample.valid && (selGain == GAIN_UNITY) && (selOfs == OFS_ZERO) |=>
      result.valid && (result.data == $past(sample.raw));
  endproperty
  a_unity_pass: assert property (p_unity_pass) else $error("Unity not identity"); // RULE18

endmodule : arbcr_regs

`default_nettype wire

// ---- rtl/arbcr_pkg.sv ----
// Shared constants and types for the converter repeat, buffer and calibration register bank.
// Assumes a 14-bit byte address space seen by the register bus slave.
package arbcr_pkg;

  // ===========================================================================
  // Address map (byte addresses)
  localparam int ADDR_W = 14;
  localparam int NUM_CAL = 8;
  typedef logic [ADDR_W-1:0] arbcr_addr_t;
  localparam arbcr_addr_t ADDR_REPEAT = 14'h21F0;
  localparam arbcr_addr_t ADDR_LOCK = 14'h2230;
  localparam arbcr_addr_t ADDR_BUFCFG = 14'h238C;
  // Entry order: low power, high speed, temperature, aux gain 1, 1.5, 2, 4, 9
  localparam arbcr_addr_t OFS_ADDR [NUM_CAL] = '{14'h2288, 14'h2234, 14'h223C, 14'h2244,
                                                 14'h22CC, 14'h22C8, 14'h22D4, 14'h22D0};
  localparam arbcr_addr_t GAIN_ADDR [NUM_CAL] = '{14'h228C, 14'h2284, 14'h2238, 14'h2240,
                                                  14'h2270, 14'h2274, 14'h2278, 14'h2298};

  // ===========================================================================
  // Field layout, masks and reset values
  localparam int REP_EN_BIT = 0;
  localparam int REP_CNT_LSB = 4;
  localparam int REP_CNT_MSB = 11;
  localparam int AMP_LSB = 4;
  localparam int AMP_MSB = 8;
  localparam int CHOP_MSB = 3;
  localparam int CAL_W = 15;
  localparam logic [31:0] REPEAT_MASK = 32'h00000FF1;
  localparam logic [31:0] BUFCFG_MASK = 32'h000001FF;
  localparam logic [31:0] REPEAT_RST = 32'h00000160;
  localparam logic [31:0] BUFCFG_RST = 32'h005F3D00;
  // Upper part of the buffer word reads back fixed, matching its reset image
  localparam logic [31:0] BUFCFG_FIXED = 32'h005F3C00;
  localparam logic [31:0] LOCK_RST = 32'h00000000;
  localparam logic [31:0] CAL_KEY = 32'hDE87A5AF;
  localparam logic [CAL_W-1:0] GAIN_UNITY = 15'h4000;
  localparam logic [CAL_W-1:0] OFS_ZERO = 15'h0000;
  localparam logic [CAL_W-1:0] GAIN_ZERO = 15'h0000;
  // Quarter-LSB offset (2 bits) plus 14 fractional gain bits
  localparam int CAL_SHIFT = 16;
  localparam logic [15:0] RESULT_MAX = 16'hFFFF;

  // ===========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================================
  // Channel selection and carriers
  typedef enum logic [2:0] {
    CH_LOW_POWER = 3'h0, CH_HIGH_SPEED = 3'h1, CH_TEMP = 3'h2, CH_AUX_G1 = 3'h3,
    CH_AUX_G1P5 = 3'h4, CH_AUX_G2 = 3'h5, CH_AUX_G4 = 3'h6, CH_AUX_G9 = 3'h7
  } arbcr_chan_t;

  typedef struct packed {
    logic valid;
    arbcr_chan_t chan;
    logic [15:0] raw;
  } arbcr_sample_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } arbcr_result_t;

  typedef struct packed {
    logic repeatEnable;
    logic [7:0] repeatCount;
    logic [4:0] amplifierOffBits;
    logic [3:0] choppingOffBits;
  } arbcr_analog_t;

endpackage : arbcr_pkg

// ---- verification/arbcr_regs_test.sv ----
// Self-checking bench for the converter repeat, buffer and calibration register bank.
// Assumes arbcr_pkg and arbcr_regs are compiled first; bench acts as AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module arbcr_regs_test import arbcr_pkg::*;;
  // ==========================================================
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  arbcr_addr_t awaddr = '0;
  arbcr_addr_t araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, calUnlocked;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  arbcr_sample_t sample = '0;
  arbcr_result_t result;
  arbcr_analog_t analogCtrl;
  int n_errors = 0;
  int total_checks = 0;
  logic [14:0] ofsTab [NUM_CAL];
  logic [14:0] gainTab [NUM_CAL];

  arbcr_regs dut (
    .clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample(sample), .result(result), .analogCtrl(analogCtrl), .calUnlocked(calUnlocked)
  );

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // Closing report and bus tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic timed_out();
    n_errors++;
    $display("wrong value at %0t: bus wait ran out", $time);
    finish_test();
  endtask : timed_out

  task automatic apply_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
  endtask : apply_reset

  // Ready is read at the falling edge, so it is the value the next rising edge samples
  task automatic wr(input arbcr_addr_t a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] expResp);
    int n;
    logic awOpen, wOpen, awTake, wTake;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awOpen = 1'b1;
    wOpen = 1'b1;
    for (n = 0; n < 20 && (awOpen || wOpen); n++)
    begin
      @(negedge clock);
      awTake = awOpen && awready;
      wTake = wOpen && wready;
      @(posedge clock);
      awOpen = awOpen && !awTake;
      wOpen = wOpen && !wTake;
      awvalid <= awOpen;
      wvalid <= wOpen;
    end
    for (n = 0; n < 20 && !bvalid; n++)
      @(negedge clock);
    if (awOpen || wOpen || !bvalid)
      timed_out();
    `CHK(bresp, expResp)
    @(posedge clock);
    bready <= 1'b0;
  endtask : wr

  // Rready rises only a cycle after rvalid, so the slave must hold its answer
  task automatic rd_chk(input arbcr_addr_t a, input logic [31:0] expData,
                        input logic [1:0] expResp);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(negedge clock);
      if (arready)
        break;
    end
    if (!arready)
      timed_out();
    @(posedge clock);
    arvalid <= 1'b0;
    for (n = 0; n < 20 && !rvalid; n++)
      @(negedge clock);
    if (!rvalid)
      timed_out();
    @(posedge clock);
    rready <= 1'b1;
    @(negedge clock);
    `CHK(rdata, expData)
    `CHK(rresp, expResp)
    @(posedge clock);
    rready <= 1'b0;
  endtask : rd_chk

  // Reference correction: quarter-LSB offset, 14 fractional gain bits, clamped
  function automatic logic [15:0] corr(input logic [15:0] raw, input logic [14:0] ofs,
                                       input logic [14:0] g);
    longint v;
    v = ((longint'(raw) * 4 + longint'($signed(ofs))) * longint'(g)) >>> 16;
    if (v < 0)
      return 16'h0000;
    if (v > 65535)
      return 16'hFFFF;
    return v[15:0];
  endfunction : corr

  task automatic send_sample(input int c, input logic [15:0] raw, input logic [15:0] exp);
    @(posedge clock);
    sample <= '{valid: 1'b1, chan: arbcr_chan_t'(c), raw: raw};
    @(posedge clock);
    sample.valid <= 1'b0;
    @(negedge clock);
    `CHK(result.valid, 1'b1)
    `CHK(result.data, exp)
    @(negedge clock);
    `CHK(result.valid, 1'b0)
    `CHK(result.data, exp)
  endtask : send_sample

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    int i;
    rd_chk(ADDR_REPEAT, 32'h00000160, RESP_OKAY);
    rd_chk(ADDR_BUFCFG, 32'h005F3D00, RESP_OKAY);
    rd_chk(ADDR_LOCK, 32'h00000000, RESP_OKAY);
    `CHK(analogCtrl, arbcr_analog_t'{1'b0, 8'h16, 5'h10, 4'h0})
    `CHK(calUnlocked, 1'b0)
    for (i = 0; i < NUM_CAL; i++)
    begin
      rd_chk(OFS_ADDR[i], 32'h00000000, RESP_OKAY);
      rd_chk(GAIN_ADDR[i], 32'h00004000, RESP_OKAY);
    end
    $display("test_reset done");
  endtask : test_reset

  task automatic test_repeat();
    wr(ADDR_REPEAT, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    rd_chk(ADDR_REPEAT, 32'h00000FF1, RESP_OKAY);
    `CHK(analogCtrl.repeatCount, 8'hFF)
    `CHK(analogCtrl.repeatEnable, 1'b1)
    wr(ADDR_REPEAT, 32'h00000010, 4'hF, RESP_OKAY);
    `CHK(analogCtrl.repeatCount, 8'h01)
    `CHK(analogCtrl.repeatEnable, 1'b0)
    // Unmapped and unaligned places answer with an error and read zero
    wr(14'h21F4, 32'h12345678, 4'hF, RESP_SLVERR);
    rd_chk(14'h2000, 32'h00000000, RESP_SLVERR);
    rd_chk(14'h21F2, 32'h00000000, RESP_SLVERR);
    $display("test_repeat done");
  endtask : test_repeat

  task automatic test_bufcfg();
    int i;
    // Walk a single one through every amplifier and chopping bit
    for (i = 0; i < 9; i++)
    begin
      wr(ADDR_BUFCFG, 32'h1 << i, 4'hF, RESP_OKAY);
      `CHK({analogCtrl.amplifierOffBits, analogCtrl.choppingOffBits}, 9'(1 << i))
      rd_chk(ADDR_BUFCFG, 32'h005F3C00 | (32'h1 << i), RESP_OKAY);
    end
    wr(ADDR_BUFCFG, 32'h005F3D0F, 4'hF, RESP_OKAY);
    rd_chk(ADDR_BUFCFG, 32'h005F3D0F, RESP_OKAY);
    `CHK(analogCtrl.choppingOffBits, 4'hF)
    wr(ADDR_BUFCFG, 32'h005F3D04, 4'hF, RESP_OKAY);
    `CHK(analogCtrl.amplifierOffBits, 5'h10)
    `CHK(analogCtrl.choppingOffBits, 4'h4)
    wr(ADDR_BUFCFG, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    rd_chk(ADDR_BUFCFG, 32'h005F3DFF, RESP_OKAY);
    // Low-frequency measurement: software clears every chopping-off bit
    wr(ADDR_BUFCFG, 32'h005F3D00, 4'hF, RESP_OKAY);
    `CHK(analogCtrl.choppingOffBits, 4'h0)
    $display("test_bufcfg done");
  endtask : test_bufcfg

  task automatic test_lock();
    wr(GAIN_ADDR[2], 32'h00001234, 4'hF, RESP_OKAY);
    rd_chk(GAIN_ADDR[2], 32'h00004000, RESP_OKAY);
    // Half a key must not unlock; the second half completes it
    wr(ADDR_LOCK, 32'hDE87A5AF, 4'h3, RESP_OKAY);
    `CHK(calUnlocked, 1'b0)
    wr(ADDR_LOCK, 32'hDE87A5AF, 4'hC, RESP_OKAY);
    `CHK(calUnlocked, 1'b1)
    rd_chk(ADDR_LOCK, 32'hDE87A5AF, RESP_OKAY);
    wr(GAIN_ADDR[2], 32'hFFFF9234, 4'hF, RESP_OKAY);
    rd_chk(GAIN_ADDR[2], 32'h00001234, RESP_OKAY);
    rd_chk(GAIN_ADDR[3], 32'h00004000, RESP_OKAY);
    wr(ADDR_LOCK, 32'h00000001, 4'hF, RESP_OKAY);
    `CHK(calUnlocked, 1'b0)
    wr(OFS_ADDR[2], 32'h00000055, 4'hF, RESP_OKAY);
    rd_chk(OFS_ADDR[2], 32'h00000000, RESP_OKAY);
    // Reset in mid-run relocks and restores every value
    apply_reset();
    test_reset();
    $display("test_lock done");
  endtask : test_lock

  task automatic test_correction();
    int i;
    logic [14:0] eo [5] = '{15'h3FFF, 15'h0000, 15'h4000, 15'h3FFF, 15'h0000};
    logic [14:0] eg [5] = '{15'h7FFF, 15'h0000, 15'h4000, 15'h4000, 15'h4000};
    logic [15:0] er [5] = '{16'hFFFF, 16'h1234, 16'h0100, 16'h0010, 16'hA5A5};
    wr(ADDR_LOCK, 32'hDE87A5AF, 4'hF, RESP_OKAY);
    for (i = 0; i < NUM_CAL; i++)
    begin
      ofsTab[i] = 15'(i * 4 - 8);
      gainTab[i] = 15'h4000 + 15'(i * 1024);
      wr(OFS_ADDR[i], {17'h0, ofsTab[i]}, 4'hF, RESP_OKAY);
      wr(GAIN_ADDR[i], {17'h0, gainTab[i]}, 4'hF, RESP_OKAY);
    end
    for (i = 0; i < NUM_CAL; i++)
      send_sample(i, 16'h1200 + 16'(i), corr(16'h1200 + 16'(i), ofsTab[i], gainTab[i]));
    // Full-scale gain and code, illegal zero gain, offset extremes, plain unity
    for (i = 0; i < 5; i++)
    begin
      wr(OFS_ADDR[3], {17'h0, eo[i]}, 4'hF, RESP_OKAY);
      wr(GAIN_ADDR[3], {17'h0, eg[i]}, 4'hF, RESP_OKAY);
      send_sample(3, er[i], corr(er[i], eo[i], eg[i]));
    end
    // Back-to-back samples on different channels
    @(posedge clock);
    sample <= '{valid: 1'b1, chan: CH_HIGH_SPEED, raw: 16'h0800};
    @(posedge clock);
    sample <= '{valid: 1'b1, chan: CH_TEMP, raw: 16'h0900};
    @(negedge clock);
    `CHK(result.data, corr(16'h0800, ofsTab[1], gainTab[1]))
    @(posedge clock);
    sample.valid <= 1'b0;
    @(negedge clock);
    `CHK(result.data, corr(16'h0900, ofsTab[2], gainTab[2]))
    $display("test_correction done");
  endtask : test_correction

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_repeat();
    test_bufcfg();
    test_lock();
    test_correction();
    finish_test();
  end
endmodule : arbcr_regs_test

`default_nettype wire
